/* rtl/hts_pkg.sv */
package hts_pkg;

	// Register offsets seen by the serial register engine.
	localparam logic [7:0] OFS_TEMP_LO   = 8'h0E;
	localparam logic [7:0] OFS_TEMP_HI   = 8'h0F;
	localparam logic [7:0] OFS_CTRL      = 8'h10;
	localparam logic [7:0] OFS_STATUS    = 8'h11;
	localparam logic [7:0] OFS_HOT_LIMIT = 8'h12;
	localparam logic [7:0] OFS_TS_COUNT  = 8'h13;
	localparam logic [7:0] OFS_TS_SEC    = 8'h14;
	localparam logic [7:0] OFS_TS_MIN    = 8'h15;
	localparam logic [7:0] OFS_TS_HOUR   = 8'h16;
	localparam logic [7:0] OFS_TS_DATE   = 8'h17;
	localparam logic [7:0] OFS_TS_MONTH  = 8'h18;
	localparam logic [7:0] OFS_TS_YEAR   = 8'h19;
	localparam logic [7:0] OFS_TRIM_LO   = 8'hC4;
	localparam logic [7:0] OFS_TRIM_HI   = 8'hC5;

	// Control register bit positions.
	localparam int CTRL_EN_BIT   = 0;
	localparam int CTRL_OVW_BIT  = 1;
	localparam int CTRL_CLR_BIT  = 2;
	localparam int CTRL_IRQ_BIT  = 3;
	localparam int CTRL_SYNC_BIT = 4;

	// Status register bit position.
	localparam int STAT_FLAG_BIT = 0;

	// Reset, fill and count step values.
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;
	localparam logic [3:0]  NIBBLE_ZERO   = 4'h0;
	localparam logic [7:0]  COUNT_STEP    = 8'h01;
	localparam logic [7:0]  HOT_LIMIT_RST = 8'h7F;
	localparam logic [11:0] TEMP_RST      = 12'h000;

	// Trim word that shifts nothing: 64/128 - 0.5 is zero degrees.
	localparam logic [15:0] TRIM_ZERO  = 16'h0040;
	// Trim steps are 1/128 degree, reading steps are 1/16 degree.
	localparam int          TRIM_SHIFT = 3;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_COMPARE = 2'b01,
		ST_HOLD    = 2'b10
	} cap_state_t;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} cal_t;

	typedef struct packed {
		logic [7:0] count;
		cal_t       stamp;
	} bank_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage : hts_pkg

/* rtl/temp_trim.sv */
`timescale 1ns/1ps
`default_nettype none

module temp_trim #(
	parameter logic [15:0] TRIM_ZERO = hts_pkg::TRIM_ZERO
) (
	input  wire logic [11:0] raw_temp,
	input  wire logic [15:0] trim,
	output logic      [11:0] adj_temp
);

	logic signed [16:0] delta;
	logic signed [16:0] step;

	// Signed trim relative to the neutral word, rescaled to reading units.
	assign delta    = $signed({trim[15], trim}) - $signed({TRIM_ZERO[15], TRIM_ZERO});
	assign step     = delta >>> hts_pkg::TRIM_SHIFT;
	// The sum wraps; trims beyond the reading range are not meaningful anyway.
	assign adj_temp = raw_temp + step[11:0];

endmodule : temp_trim

`default_nettype wire

/* rtl/high_temp_timestamp.sv */
`timescale 1ns/1ps
`default_nettype none

module high_temp_timestamp #(
	parameter logic [7:0]  HOT_LIMIT_RST = hts_pkg::HOT_LIMIT_RST,
	parameter logic [15:0] TRIM_RST      = hts_pkg::TRIM_ZERO
) (
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic              tick_1hz,
	input  wire logic              clock_halt,
	input  wire logic              sec_write,
	input  wire logic              external_event_pin,
	input  wire logic              ts_read_busy,
	input  wire hts_pkg::cal_t     cal_in,
	input  wire logic [11:0]       raw_temp,
	input  wire hts_pkg::reg_req_t reg_req,
	output logic      [7:0]        reg_rdata,
	output logic                   sec_tick,
	output logic                   prescaler_clear,
	output logic      [11:0]       comp_temp,
	output logic                   irq_output_n
);

	// Write strobe for one register offset.
	function automatic logic wr_hit(input hts_pkg::reg_req_t req, input logic [7:0] ofs);
		wr_hit = req.wr && (req.addr == ofs);
	endfunction : wr_hit

	// Configuration state.
	logic                  en_r, en_nxt;
	logic                  ovw_r, ovw_nxt;
	logic                  irq_en_r, irq_en_nxt;
	logic                  sync_en_r, sync_en_nxt;
	logic [7:0]            hot_limit_r, hot_limit_nxt;
	logic [15:0]           trim_r, trim_nxt;
	// Measurement and capture state.
	hts_pkg::cap_state_t   state_r, state_nxt;
	logic [11:0]           reading_r, reading_nxt;
	hts_pkg::bank_t        bank_r, bank_nxt;
	logic                  flag_r, flag_nxt;
	logic                  capture;
	// Port-facing state.
	logic [7:0]            rdata_r, rdata_nxt;
	logic                  irq_n_r, irq_n_nxt;
	logic                  pin_prev_r, pin_prev_nxt;
	logic                  pclr_r, pclr_nxt;
	logic [11:0]           comp_r, comp_nxt;

	logic                  clear_req;
	logic                  flag_clr;
	logic                  ext_edge;
	logic                  resync;
	logic                  hit;
	logic [11:0]           adj_temp;

	// The trim path feeds the stored reading, which is both reported and used for the hot compare.
	temp_trim #(
		.TRIM_ZERO (hts_pkg::TRIM_ZERO)
	) u_trim (
		.raw_temp (raw_temp),
		.trim     (trim_r),
		.adj_temp (adj_temp)
	);

	// Decoded strobes and events shared by several groups.
	assign clear_req = wr_hit(reg_req, hts_pkg::OFS_CTRL) && reg_req.wdata[hts_pkg::CTRL_CLR_BIT];
	assign flag_clr  = wr_hit(reg_req, hts_pkg::OFS_STATUS) && !reg_req.wdata[hts_pkg::STAT_FLAG_BIT];
	assign ext_edge  = external_event_pin && !pin_prev_r;
	assign resync    = sec_write || (ext_edge && sync_en_r);
	// A resync restarts the second, so the tick that would land with it is dropped.
	assign sec_tick  = tick_1hz && !clock_halt && !resync;
	assign hit       = $signed(reading_r[11:4]) > $signed(hot_limit_r);

	// Configuration registers; the sync enable clears itself after one event.
	always_comb begin
		en_nxt        = en_r;
		ovw_nxt       = ovw_r;
		irq_en_nxt    = irq_en_r;
		sync_en_nxt   = sync_en_r;
		hot_limit_nxt = hot_limit_r;
		trim_nxt      = trim_r;
		if (wr_hit(reg_req, hts_pkg::OFS_CTRL)) begin
			en_nxt      = reg_req.wdata[hts_pkg::CTRL_EN_BIT];
			ovw_nxt     = reg_req.wdata[hts_pkg::CTRL_OVW_BIT];
			irq_en_nxt  = reg_req.wdata[hts_pkg::CTRL_IRQ_BIT];
			sync_en_nxt = reg_req.wdata[hts_pkg::CTRL_SYNC_BIT];
		end
		if (ext_edge && sync_en_r) begin
			sync_en_nxt = 1'b0;
		end
		if (wr_hit(reg_req, hts_pkg::OFS_HOT_LIMIT)) begin
			hot_limit_nxt = reg_req.wdata;
		end
		if (wr_hit(reg_req, hts_pkg::OFS_TRIM_LO)) begin
			trim_nxt[7:0] = reg_req.wdata;
		end
		if (wr_hit(reg_req, hts_pkg::OFS_TRIM_HI)) begin
			trim_nxt[15:8] = reg_req.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			en_r        <= 1'b0;
			ovw_r       <= 1'b0;
			irq_en_r    <= 1'b0;
			sync_en_r   <= 1'b0;
			hot_limit_r <= HOT_LIMIT_RST;
			trim_r      <= TRIM_RST;
		end else begin
			en_r        <= en_nxt;
			ovw_r       <= ovw_nxt;
			irq_en_r    <= irq_en_nxt;
			sync_en_r   <= sync_en_nxt;
			hot_limit_r <= hot_limit_nxt;
			trim_r      <= trim_nxt;
		end
	end

	// Measure on the tick, compare one cycle later, capture unless a read holds it off.
	always_comb begin
		state_nxt   = state_r;
		reading_nxt = reading_r;
		bank_nxt    = bank_r;
		flag_nxt    = flag_r;
		capture     = 1'b0;
		if (sec_tick) begin
			reading_nxt = adj_temp;
		end
		if (clear_req) begin
			bank_nxt = '0;
			flag_nxt = 1'b0;
		end
		if (flag_clr) begin
			flag_nxt = 1'b0;
		end
		unique case (state_r)
			hts_pkg::ST_IDLE: begin
				if (sec_tick) begin
					state_nxt = hts_pkg::ST_COMPARE;
				end
			end
			hts_pkg::ST_COMPARE: begin
				state_nxt = hts_pkg::ST_IDLE;
				if (en_r && hit && !clock_halt) begin
					if (ts_read_busy) begin
						state_nxt = hts_pkg::ST_HOLD;
					end else begin
						capture = 1'b1;
					end
				end
			end
			hts_pkg::ST_HOLD: begin
				// Disabling while held drops the pending event.
				if (!en_r) begin
					state_nxt = hts_pkg::ST_IDLE;
				end else if (!ts_read_busy) begin
					capture   = 1'b1;
					state_nxt = hts_pkg::ST_IDLE;
				end
			end
			default: begin
				state_nxt = hts_pkg::ST_IDLE;
			end
		endcase
		// An event in the clearing cycle lands on the cleared bank and is kept.
		if (capture) begin
			if (ovw_r || (bank_nxt == '0)) begin
				bank_nxt.stamp = cal_in;
			end
			bank_nxt.count = bank_nxt.count + hts_pkg::COUNT_STEP;
			flag_nxt       = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_r   <= hts_pkg::ST_IDLE;
			reading_r <= hts_pkg::TEMP_RST;
			bank_r    <= '0;
			flag_r    <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			reading_r <= reading_nxt;
			bank_r    <= bank_nxt;
			flag_r    <= flag_nxt;
		end
	end

	// Read data, interrupt pin, event edge and resync pulse.
	always_comb begin
		rdata_nxt    = rdata_r;
		irq_n_nxt    = !(flag_nxt && irq_en_nxt);
		pin_prev_nxt = external_event_pin;
		pclr_nxt     = resync;
		comp_nxt     = comp_r;
		if (sec_tick) begin
			comp_nxt = raw_temp;
		end
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				hts_pkg::OFS_TEMP_LO:   rdata_nxt = {reading_r[3:0], hts_pkg::NIBBLE_ZERO};
				hts_pkg::OFS_TEMP_HI:   rdata_nxt = reading_r[11:4];
				hts_pkg::OFS_CTRL: begin
					rdata_nxt = hts_pkg::BYTE_ZERO;
					rdata_nxt[hts_pkg::CTRL_EN_BIT]   = en_r;
					rdata_nxt[hts_pkg::CTRL_OVW_BIT]  = ovw_r;
					rdata_nxt[hts_pkg::CTRL_IRQ_BIT]  = irq_en_r;
					rdata_nxt[hts_pkg::CTRL_SYNC_BIT] = sync_en_r;
				end
				hts_pkg::OFS_STATUS: begin
					rdata_nxt = hts_pkg::BYTE_ZERO;
					rdata_nxt[hts_pkg::STAT_FLAG_BIT] = flag_r;
				end
				hts_pkg::OFS_HOT_LIMIT: rdata_nxt = hot_limit_r;
				hts_pkg::OFS_TS_COUNT:  rdata_nxt = bank_r.count;
				hts_pkg::OFS_TS_SEC:    rdata_nxt = bank_r.stamp.second;
				hts_pkg::OFS_TS_MIN:    rdata_nxt = bank_r.stamp.minute;
				hts_pkg::OFS_TS_HOUR:   rdata_nxt = bank_r.stamp.hour;
				hts_pkg::OFS_TS_DATE:   rdata_nxt = bank_r.stamp.date;
				hts_pkg::OFS_TS_MONTH:  rdata_nxt = bank_r.stamp.month;
				hts_pkg::OFS_TS_YEAR:   rdata_nxt = bank_r.stamp.year;
				hts_pkg::OFS_TRIM_LO:   rdata_nxt = trim_r[7:0];
				hts_pkg::OFS_TRIM_HI:   rdata_nxt = trim_r[15:8];
				default:                rdata_nxt = hts_pkg::BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			rdata_r    <= hts_pkg::BYTE_ZERO;
			irq_n_r    <= 1'b1;
			pin_prev_r <= 1'b0;
			pclr_r     <= 1'b0;
			comp_r     <= hts_pkg::TEMP_RST;
		end else begin
			rdata_r    <= rdata_nxt;
			irq_n_r    <= irq_n_nxt;
			pin_prev_r <= pin_prev_nxt;
			pclr_r     <= pclr_nxt;
			comp_r     <= comp_nxt;
		end
	end

	assign reg_rdata       = rdata_r;
	assign irq_output_n    = irq_n_r;
	assign prescaler_clear = pclr_r;
	assign comp_temp       = comp_r;

	// Checks on the capture path, its register side effects and the resync pulse.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_no_cap_disabled: assert property (capture |-> en_r)
		else $error("Capture while disabled.");
	a_stamp_overwrite: assert property (
		(state_r == hts_pkg::ST_COMPARE && en_r && hit && !clock_halt && !ts_read_busy && ovw_r)
		|=> (bank_r.stamp == $past(cal_in)) && flag_r)
		else $error("Overwrite mode did not copy the calendar.");
	a_first_kept: assert property (
		(capture && !ovw_r && !clear_req && (bank_r != '0)) |=> (bank_r.stamp == $past(bank_r.stamp)))
		else $error("First-event stamp was overwritten.");
	a_count_step: assert property (
		(capture && !clear_req) |=> (bank_r.count == $past(bank_r.count) + hts_pkg::COUNT_STEP))
		else $error("Event count did not advance by one.");
	a_clear_bank: assert property ((clear_req && !capture) |=> (bank_r == '0) && !flag_r)
		else $error("Clear did not empty the bank.");
	a_clear_reads0: assert property (
		(reg_req.rd && reg_req.addr == hts_pkg::OFS_CTRL) |=> !reg_rdata[hts_pkg::CTRL_CLR_BIT])
		else $error("Clear bit read back as one.");
	a_halt_quiet: assert property (
		(clock_halt && state_r == hts_pkg::ST_IDLE) |=> (state_r == hts_pkg::ST_IDLE) && $stable(reading_r))
		else $error("Measurement ran while halted.");
	a_read_block: assert property (ts_read_busy |-> !capture)
		else $error("Capture during a bank read.");
	a_irq_follow: assert property ((capture && irq_en_nxt) |=> flag_r && !irq_output_n)
		else $error("Interrupt not raised on an enabled event.");
	a_resync_pulse: assert property (resync |-> !sec_tick ##1 prescaler_clear)
		else $error("Resync produced a tick or no clear.");

	c_capture_first: cover property (capture && !ovw_r && bank_r == '0);
	c_capture_held:  cover property (state_r == hts_pkg::ST_HOLD ##[1:20] capture);
	c_clear_event:   cover property (clear_req && capture);
	c_count_wrap:    cover property (capture && bank_r.count == 8'hFF);

endmodule : high_temp_timestamp

`default_nettype wire

/* test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module host_model (
	input  wire logic         mclk,
	output var hts_pkg::reg_req_t reg_req,
	input  wire logic [7:0]   reg_rdata
);

	// The port idles with both strobes low, so nothing is taken by accident.
	initial begin
		reg_req = '0;
	end

	// One write strobe, changed only at falling edges, so the rising edge sees it settled.
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(negedge mclk);
		reg_req = '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
		@(negedge mclk);
		reg_req.wr = 1'b0;
	endtask : write_reg

	// Read data is registered and holds, so it is sampled one edge late to be safe.
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(negedge mclk);
		reg_req = '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(negedge mclk);
		reg_req.rd = 1'b0;
		@(negedge mclk);
		data = reg_rdata;
	endtask : read_reg

endmodule : host_model

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;

	logic              mclk = 1'b0;
	logic              resetn;
	logic              external_event_pin;
	logic              tick_1hz;
	logic              clock_halt;
	logic              sec_write;
	logic              ts_read_busy;
	hts_pkg::cal_t     cal_in;
	logic [11:0]       raw_temp;
	hts_pkg::reg_req_t reg_req;
	logic [7:0]        reg_rdata;
	logic              sec_tick;
	logic              prescaler_clear;
	logic [11:0]       comp_temp;
	logic              irq_output_n;
	int                err_count;
	int                n_tests;
	localparam hts_pkg::cal_t CAL_A = 48'h250615103045;
	localparam hts_pkg::cal_t CAL_B = 48'h250615103100;
	localparam hts_pkg::cal_t CAL_C = 48'h261231235958;

	// Free-running 100 MHz clock.
	always #5 mclk = ~mclk;

	high_temp_timestamp high_temp_timestamp_i (
		.mclk               (mclk),
		.resetn             (resetn),
		.tick_1hz           (tick_1hz),
		.clock_halt         (clock_halt),
		.sec_write          (sec_write),
		.external_event_pin (external_event_pin),
		.ts_read_busy       (ts_read_busy),
		.cal_in             (cal_in),
		.raw_temp           (raw_temp),
		.reg_req            (reg_req),
		.reg_rdata          (reg_rdata),
		.sec_tick           (sec_tick),
		.prescaler_clear    (prescaler_clear),
		.comp_temp          (comp_temp),
		.irq_output_n       (irq_output_n)
	);

	host_model host_model_i (
		.mclk      (mclk),
		.reg_req   (reg_req),
		.reg_rdata (reg_rdata)
	);

	// Case inequality, so an unknown never counts as a match.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		host_model_i.read_reg(addr, d);
		check($sformatf("reg %h", addr), {8'h00, d}, {8'h00, exp});
	endtask : chk_reg

	// Count first, then seconds up to year at consecutive offsets.
	task automatic check_bank(input logic [7:0] cnt, input hts_pkg::cal_t c);
		chk_reg(hts_pkg::OFS_TS_COUNT, cnt);
		for (int i = 0; i < 6; i++) begin
			chk_reg(hts_pkg::OFS_TS_SEC + 8'(i), c[8*i +: 8]);
		end
	endtask : check_bank

	// One prescaler tick, then enough cycles for compare and capture to land.
	task automatic tick(input logic exp_tick);
		@(negedge mclk);
		tick_1hz = 1'b1;
		#1 check("sec_tick", {15'h0000, sec_tick}, {15'h0000, exp_tick});
		@(negedge mclk);
		tick_1hz = 1'b0;
		repeat (4) @(negedge mclk);
	endtask : tick

	task automatic end_sim();
		$display("Counts: %0d checks, %0d mismatches", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_sim

	// The whole run needs about 1900 cycles; a hang is cut off well past that.
	initial begin
		repeat (40000) @(posedge mclk);
		err_count++;
		end_sim();
	end

	// Main sequence; every input changes only at falling edges.
	initial begin
		{resetn, tick_1hz, clock_halt, sec_write, ts_read_busy, external_event_pin} = 6'h00;
		cal_in = CAL_A;
		raw_temp = 12'h200;
		err_count = 0;
		n_tests = 0;
		repeat (16) @(negedge mclk);
		resetn = 1'b1;
		check_bank(8'h00, 48'h0);
		chk_reg(hts_pkg::OFS_CTRL, 8'h00);
		chk_reg(hts_pkg::OFS_HOT_LIMIT, hts_pkg::HOT_LIMIT_RST);
		chk_reg(hts_pkg::OFS_TRIM_LO, 8'h40);
		chk_reg(hts_pkg::OFS_TRIM_HI, 8'h00);
		chk_reg(8'h20, 8'h00);
		check("irq", {15'h0000, irq_output_n}, 16'h0001);
		$display("Test reset done");
		host_model_i.write_reg(hts_pkg::OFS_CTRL, 8'h00);
		host_model_i.write_reg(hts_pkg::OFS_HOT_LIMIT, 8'h10);
		host_model_i.write_reg(hts_pkg::OFS_CTRL, 8'h04);
		tick(1'b1);
		check_bank(8'h00, 48'h0);
		host_model_i.write_reg(hts_pkg::OFS_CTRL, 8'h01);
		tick(1'b1);
		check_bank(8'h01, CAL_A);
		chk_reg(hts_pkg::OFS_STATUS, 8'h01);
		check("irq", {15'h0000, irq_output_n}, 16'h0001);
		cal_in = CAL_B;
		tick(1'b1);
		check_bank(8'h02, CAL_A);
		$display("Test first event done");
		host_model_i.write_reg(hts_pkg::OFS_CTRL, 8'h0B);
		repeat (2) @(negedge mclk);
		check("irq", {15'h0000, irq_output_n}, 16'h0000);
		cal_in = CAL_C;
		tick(1'b1);
		check_bank(8'h03, CAL_C);
		host_model_i.write_reg(hts_pkg::OFS_CTRL, 8'h0F);
		check_bank(8'h00, 48'h0);
		chk_reg(hts_pkg::OFS_STATUS, 8'h00);
		chk_reg(hts_pkg::OFS_CTRL, 8'h0B);
		check("irq", {15'h0000, irq_output_n}, 16'h0001);
		$display("Test overwrite and clear done");
		clock_halt = 1'b1;
		tick(1'b0);
		clock_halt = 1'b0;
		raw_temp = 12'h100;
		tick(1'b1);
		check_bank(8'h00, 48'h0);
		check("comp_temp", {4'h0, comp_temp}, 16'h0100);
		host_model_i.write_reg(hts_pkg::OFS_TRIM_LO, 8'hC0);
		tick(1'b1);
		check_bank(8'h01, CAL_C);
		chk_reg(hts_pkg::OFS_TEMP_HI, 8'h11);
		chk_reg(hts_pkg::OFS_TEMP_LO, 8'h00);
		check("comp_temp", {4'h0, comp_temp}, 16'h0100);
		$display("Test halt and trim done");
		ts_read_busy = 1'b1;
		tick(1'b1);
		chk_reg(hts_pkg::OFS_TS_COUNT, 8'h01);
		ts_read_busy = 1'b0;
		repeat (4) @(negedge mclk);
		chk_reg(hts_pkg::OFS_TS_COUNT, 8'h02);
		// Writing zero to the status flag clears it and lets the interrupt go.
		check("irq", {15'h0000, irq_output_n}, 16'h0000);
		host_model_i.write_reg(hts_pkg::OFS_STATUS, 8'h00);
		chk_reg(hts_pkg::OFS_STATUS, 8'h00);
		check("irq", {15'h0000, irq_output_n}, 16'h0001);
		@(negedge mclk);
		sec_write = 1'b1;
		tick_1hz = 1'b1;
		#1 check("sec_tick", {15'h0000, sec_tick}, 16'h0000);
		@(negedge mclk);
		check("prescaler_clear", {15'h0000, prescaler_clear}, 16'h0001);
		sec_write = 1'b0;
		tick_1hz = 1'b0;
		repeat (4) @(negedge mclk);
		chk_reg(hts_pkg::OFS_TS_COUNT, 8'h02);
		// A pin edge with sync enabled resyncs once and then drops the enable.
		host_model_i.write_reg(hts_pkg::OFS_CTRL, 8'h1B);
		chk_reg(hts_pkg::OFS_CTRL, 8'h1B);
		@(negedge mclk);
		external_event_pin = 1'b1;
		tick_1hz = 1'b1;
		#1 check("sec_tick", {15'h0000, sec_tick}, 16'h0000);
		@(negedge mclk);
		check("prescaler_clear", {15'h0000, prescaler_clear}, 16'h0001);
		tick_1hz = 1'b0;
		@(negedge mclk);
		check("prescaler_clear", {15'h0000, prescaler_clear}, 16'h0000);
		external_event_pin = 1'b0;
		chk_reg(hts_pkg::OFS_CTRL, 8'h0B);
		chk_reg(hts_pkg::OFS_TS_COUNT, 8'h02);
		$display("Test busy and resync done");
		// Two events already counted, so 254 more must wrap the count to zero.
		for (int i = 0; i < 254; i++) begin
			tick(1'b1);
		end
		chk_reg(hts_pkg::OFS_TS_COUNT, 8'h00);
		$display("Test count wrap done");
		// A reset in mid-run must empty a bank that now holds a stamp and a flag.
		@(negedge mclk);
		resetn = 1'b0;
		repeat (2) @(negedge mclk);
		resetn = 1'b1;
		check_bank(8'h00, 48'h0);
		chk_reg(hts_pkg::OFS_STATUS, 8'h00);
		check("irq", {15'h0000, irq_output_n}, 16'h0001);
		$display("Test mid-run reset done");
		end_sim();
	end

endmodule : tb_top

`default_nettype wire
